// ### verilog/sla_adaptor.sv
`timescale 1ns/1ns
`include "sla_regs.svh"
module sla_adaptor
  import sla_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       mode_strap,
  input  wire logic       serial_rx_pin,
  output logic            serial_tx_pin,
  input  wire logic [7:0] tx_side_bus,
  input  wire logic       tx_side_valid,
  output logic            tx_side_ack,
  output logic      [7:0] rx_side_bus,
  output logic            rx_side_valid,
  input  wire logic       rx_side_ack,
  input  wire logic       reg_select_low,
  input  wire logic       reg_select_high,
  input  wire logic       read_not_write,
  input  wire logic       chip_select_n,
  input  wire logic [7:0] host_bus_in,
  output logic      [7:0] host_bus_out,
  output logic            host_bus_oe,
  output logic            rx_irq,
  output logic            tx_irq
);

  localparam logic [4:0] BIT_SLOW = 5'(`SLA_BIT_CYC_SLOW);  // Cycles per bit at 10 Mbit/s.
  localparam logic [4:0] BIT_FAST = 5'(`SLA_BIT_CYC_FAST);  // Cycles per bit at 20 Mbit/s.

  logic          rst_meta;      // Reset synchroniser, first stage.
  logic          rst_n;         // Reset released in step with the clock.
  sla_mode_e     mode;          // Mode decided from the strap.
  logic          fast;          // Link runs at the higher rate.
  logic [7:0]    strap_cnt;     // Strap observation timer.
  logic          strap_q;       // Previous strap sample.
  logic          strap_moved;   // Strap toggled, so it follows the reference clock.
  logic [4:0]    bit_cyc;       // Active bit period.
  sla_rx_e       rx_state;      // Deserialiser state.
  logic          rx_prev;       // Previous line sample for the start edge.
  logic [4:0]    rx_tmr;        // Cycles to the next mid-bit sample.
  logic [3:0]    rx_idx;        // Bit index within the packet.
  logic [7:0]    rx_sr;         // Data bits being gathered.
  logic          ack_seen;      // One-cycle pulse: acknowledge packet arrived.
  logic          rx_pend;       // Complete byte waiting to enter the buffer.
  logic [7:0]    rx_hold;       // That byte.
  logic          buf_in_ready;  // Buffer has room.
  logic          buf_valid;     // Buffer holds a byte for the consumer.
  logic [7:0]    buf_data;      // Oldest buffered byte.
  logic          buf_pop;       // Consumer takes the oldest byte.
  logic [10:0]   tx_sr;         // Packet bits, sent from bit 0.
  logic [3:0]    tx_left;       // Bits still to send.
  logic [4:0]    tx_tmr;        // Cycles left in the current bit.
  logic          ack_req;       // Acknowledge packet owed to the far end.
  logic          data_req;      // Data packet waiting to go.
  logic [7:0]    tx_data;       // Byte to send.
  logic          tx_start_ack;  // Loading an acknowledge this cycle.
  logic          tx_start_dat;  // Loading a data packet this cycle.
  sla_hs_e       th_state;      // Byte-port transmit handshake.
  sla_hs_e       rh_state;      // Byte-port receive handshake.
  logic          out_ready;     // Register mode: link free for a new byte.
  logic          out_ie;        // Register mode: output interrupt enable.
  logic          in_ie;         // Register mode: input interrupt enable.
  logic          cs_q;          // Previous chip select, for the falling edge.
  sla_host_req_s host_req;      // Access presented on the host pins.
  logic          host_take;     // Access taken at chip select fall.

  // Register read mux; unused status bits read zero and the write-only byte reads zero.
  function automatic logic [7:0] reg_read(input logic [1:0] sel, input logic [7:0] rxd,
                                          input logic ie_in, input logic dp,
                                          input logic ie_out, input logic rdy);
    logic [7:0] v;
    v = 8'h00;
    if (sel == `SLA_SEL_RX_BYTE)
    begin
      v = rxd;
    end
    else if (sel == `SLA_SEL_RX_STAT)
    begin
      v[`SLA_ST_FLAG] = dp;
      v[`SLA_ST_IE]   = ie_in;
    end
    else if (sel == `SLA_SEL_TX_STAT)
    begin
      v[`SLA_ST_FLAG] = rdy;
      v[`SLA_ST_IE]   = ie_out;
    end
    return v;
  endfunction

  // Reset is applied at once but released through two flops to avoid a ragged release.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // A strap that moves within the window is wired to the reference clock.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode        <= SLA_MODE_WAIT;
      fast        <= 1'b0;
      strap_cnt   <= 8'h00;
      strap_q     <= 1'b0;
      strap_moved <= 1'b0;
    end
    else if (mode == SLA_MODE_WAIT)
    begin
      strap_q   <= mode_strap;
      strap_cnt <= strap_cnt + 8'h01;
      if (strap_cnt != 8'h00 && strap_q != mode_strap)
      begin
        strap_moved <= 1'b1;
      end
      if (strap_cnt == `SLA_STRAP_WIN)
      begin
        mode <= (strap_moved || strap_q) ? SLA_MODE_BYTE : SLA_MODE_REG;
        fast <= strap_moved;
      end
    end
  end

  // Bit period counts down the system clock, scaled to multiples of the reference rate.
  assign bit_cyc = fast ? BIT_FAST : BIT_SLOW;

  // Receiver oversamples the line and re-times on each start edge, so sender phase is free.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state <= SLA_RX_IDLE;
      rx_prev  <= 1'b0;
      rx_tmr   <= 5'h00;
      rx_idx   <= 4'h0;
      rx_sr    <= 8'h00;
      ack_seen <= 1'b0;
      rx_pend  <= 1'b0;
      rx_hold  <= 8'h00;
    end
    else
    begin
      rx_prev  <= serial_rx_pin;
      ack_seen <= 1'b0;
      if (rx_pend && buf_in_ready)
      begin
        rx_pend <= 1'b0;
      end
      case (rx_state)
        SLA_RX_IDLE:
        begin
          // First sample lands mid-way through the start bit.
          if (mode != SLA_MODE_WAIT && serial_rx_pin && !rx_prev)
          begin
            rx_state <= SLA_RX_RUN;
            rx_tmr   <= (bit_cyc >> 1) - 5'h01;
            rx_idx   <= 4'h0;
          end
        end
        default:
        begin
          if (rx_tmr != 5'h00)
          begin
            rx_tmr <= rx_tmr - 5'h01;
          end
          else
          begin
            rx_tmr <= bit_cyc - 5'h01;
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == 4'h0 && !serial_rx_pin)
            begin
              // A start pulse shorter than half a bit is noise.
              rx_state <= SLA_RX_IDLE;
            end
            else if (rx_idx == 4'h1 && !serial_rx_pin)
            begin
              ack_seen <= 1'b1;
              rx_state <= SLA_RX_IDLE;
            end
            else if (rx_idx >= 4'h2 && rx_idx < `SLA_DATA_BITS - 4'h1)
            begin
              rx_sr <= {serial_rx_pin, rx_sr[7:1]};
            end
            else if (rx_idx == `SLA_DATA_BITS - 4'h1)
            begin
              // Stop bit: the byte is complete.
              rx_hold  <= rx_sr;
              rx_pend  <= 1'b1;
              rx_state <= SLA_RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Two-entry buffer decouples the deserialiser from a slow consumer.
  sla_fifo2 #(.WIDTH(8), .DEPTH(2)) u_rx_buf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (rx_pend),
    .in_ready  (buf_in_ready),
    .in_data   (rx_hold),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  // Host access is taken once, on the cycle chip select is first seen low.
  assign host_req  = '{sel: {reg_select_high, reg_select_low}, rnw: read_not_write, wdata: host_bus_in};
  assign host_take = (mode == SLA_MODE_REG) && !chip_select_n && cs_q;

  // Byte mode pops into the output latch; register mode pops on a data read.
  assign buf_pop = (mode == SLA_MODE_BYTE) ? (rh_state == SLA_HS_IDLE)
                 : (host_take && host_req.rnw && host_req.sel == `SLA_SEL_RX_BYTE);

  // Serialiser: an owed acknowledge goes before a waiting byte so the far end never stalls.
  assign tx_start_ack = (mode != SLA_MODE_WAIT) && (tx_left == 4'h0) && ack_req;
  assign tx_start_dat = (mode != SLA_MODE_WAIT) && (tx_left == 4'h0) && !ack_req && data_req;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_tx_pin <= 1'b0;
      tx_sr         <= 11'h000;
      tx_left       <= 4'h0;
      tx_tmr        <= 5'h00;
    end
    else if (tx_start_ack || tx_start_dat)
    begin
      tx_sr   <= tx_start_ack ? 11'h001 : {1'b0, tx_data, 2'h3};
      tx_left <= tx_start_ack ? `SLA_ACK_BITS : `SLA_DATA_BITS;
      tx_tmr  <= 5'h00;
    end
    else if (tx_left != 4'h0)
    begin
      if (tx_tmr == 5'h00)
      begin
        serial_tx_pin <= tx_sr[0];
        tx_sr         <= {1'b0, tx_sr[10:1]};
        tx_tmr        <= bit_cyc - 5'h01;
      end
      else
      begin
        tx_tmr <= tx_tmr - 5'h01;
        if (tx_tmr == 5'h01 && tx_left == 4'h1)
        begin
          tx_left <= 4'h0;
        end
        else if (tx_tmr == 5'h01)
        begin
          tx_left <= tx_left - 4'h1;
        end
      end
    end
    else
    begin
      serial_tx_pin <= 1'b0;
    end
  end

  // Owed acknowledges: raised when the consumer takes a byte, cleared when sent.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_req <= 1'b0;
    end
    else if ((mode == SLA_MODE_BYTE && rh_state == SLA_HS_BUSY && rx_side_ack) ||
             (mode == SLA_MODE_REG && buf_pop && buf_valid))
    begin
      ack_req <= 1'b1;
    end
    else if (tx_start_ack)
    begin
      ack_req <= 1'b0;
    end
  end

  // Byte-port transmit handshake; a new byte is only taken once the last was acknowledged.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      th_state    <= SLA_HS_IDLE;
      tx_side_ack <= 1'b0;
      data_req    <= 1'b0;
      tx_data     <= 8'h00;
      out_ready   <= 1'b1;
    end
    else if (mode == SLA_MODE_BYTE)
    begin
      if (tx_start_dat)
      begin
        data_req <= 1'b0;
      end
      case (th_state)
        SLA_HS_IDLE:
        begin
          if (tx_side_valid)
          begin
            tx_data  <= tx_side_bus;
            data_req <= 1'b1;
            th_state <= SLA_HS_BUSY;
          end
        end
        SLA_HS_BUSY:
        begin
          if (ack_seen && !data_req)
          begin
            tx_side_ack <= 1'b1;
            th_state    <= SLA_HS_DONE;
          end
        end
        default:
        begin
          if (!tx_side_valid)
          begin
            tx_side_ack <= 1'b0;
            th_state    <= SLA_HS_IDLE;
          end
        end
      endcase
    end
    else if (mode == SLA_MODE_REG)
    begin
      if (tx_start_dat)
      begin
        data_req <= 1'b0;
      end
      if (host_take && !host_req.rnw && host_req.sel == `SLA_SEL_TX_BYTE)
      begin
        tx_data   <= host_req.wdata;
        data_req  <= 1'b1;
        out_ready <= 1'b0;
      end
      // An arriving acknowledge wins over a write in the same cycle.
      if (ack_seen)
      begin
        out_ready <= 1'b1;
      end
    end
  end

  // Byte-port receive handshake, independent of the transmit side.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rh_state      <= SLA_HS_IDLE;
      rx_side_valid <= 1'b0;
      rx_side_bus   <= 8'h00;
    end
    else if (mode == SLA_MODE_BYTE)
    begin
      case (rh_state)
        SLA_HS_IDLE:
        begin
          if (buf_valid)
          begin
            rx_side_bus   <= buf_data;
            rx_side_valid <= 1'b1;
            rh_state      <= SLA_HS_BUSY;
          end
        end
        SLA_HS_BUSY:
        begin
          if (rx_side_ack)
          begin
            rx_side_valid <= 1'b0;
            rh_state      <= SLA_HS_DONE;
          end
        end
        default:
        begin
          if (!rx_side_ack)
          begin
            rh_state <= SLA_HS_IDLE;
          end
        end
      endcase
    end
  end

  // Host status/control writes; a write to the receive byte is silently dropped.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_q   <= 1'b1;
      in_ie  <= 1'b0;
      out_ie <= 1'b0;
    end
    else
    begin
      cs_q <= chip_select_n;
      if (host_take && !host_req.rnw && host_req.sel == `SLA_SEL_RX_STAT)
      begin
        in_ie <= host_req.wdata[`SLA_ST_IE];
      end
      else if (host_take && !host_req.rnw && host_req.sel == `SLA_SEL_TX_STAT)
      begin
        out_ie <= host_req.wdata[`SLA_ST_IE];
      end
    end
  end

  // Read data and interrupt lines, all registered for clean pins.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_bus_out <= 8'h00;
      host_bus_oe  <= 1'b0;
      rx_irq       <= 1'b0;
      tx_irq       <= 1'b0;
    end
    else
    begin
      // The bus is driven only during a read cycle so the host owns it otherwise.
      host_bus_oe  <= (mode == SLA_MODE_REG) && !chip_select_n && read_not_write;
      // Read data is captured at the access edge and held while chip select stays low,
      // because a data read pops the buffer and the next word must not leak onto the bus.
      if (host_take || chip_select_n)
      begin
        host_bus_out <= reg_read(host_req.sel, buf_data, in_ie, buf_valid, out_ie, out_ready);
      end
      rx_irq       <= (mode == SLA_MODE_REG) && buf_valid && in_ie;
      tx_irq       <= (mode == SLA_MODE_REG) && out_ready && out_ie;
    end
  end

endmodule

// ### common/sla_regs.svh
`ifndef SLA_REGS_SVH
`define SLA_REGS_SVH

// System clock and reference rate, in hertz.
`define SLA_CLK_HZ        125000000
`define SLA_REF_HZ        5000000
// Bit rates are multiples of the 5 MHz reference: x2 gives 10 Mbit/s, x4 gives 20 Mbit/s.
`define SLA_SLOW_MULT     2
`define SLA_FAST_MULT     4
// Bit periods in system cycles, rounded down (longest time that still meets the rate).
`define SLA_BIT_CYC_SLOW  ((`SLA_CLK_HZ) / ((`SLA_REF_HZ) * (`SLA_SLOW_MULT)))
`define SLA_BIT_CYC_FAST  ((`SLA_CLK_HZ) / ((`SLA_REF_HZ) * (`SLA_FAST_MULT)))
// Strap observation window in system cycles; covers more than two reference periods.
`define SLA_STRAP_WIN     8'h40
// Register selects, {reg_select_high, reg_select_low}.
`define SLA_SEL_RX_BYTE   2'h0
`define SLA_SEL_TX_BYTE   2'h1
`define SLA_SEL_RX_STAT   2'h2
`define SLA_SEL_TX_STAT   2'h3
// Status/control field positions.
`define SLA_ST_FLAG       0
`define SLA_ST_IE         1
// Packet lengths in bits.
`define SLA_DATA_BITS     4'hb
`define SLA_ACK_BITS      4'h2

`endif

// ### common/sla_pkg.sv
package sla_pkg;

  // Operating mode chosen by the strap.
  typedef enum logic [1:0] {SLA_MODE_WAIT, SLA_MODE_BYTE, SLA_MODE_REG} sla_mode_e;

  // Receive deserialiser states.
  typedef enum logic {SLA_RX_IDLE, SLA_RX_RUN} sla_rx_e;

  // Byte-port handshake states, one set per direction.
  typedef enum logic [1:0] {SLA_HS_IDLE, SLA_HS_BUSY, SLA_HS_DONE} sla_hs_e;

  // One host register access as captured at the chip select edge.
  typedef struct packed {
    logic [1:0] sel;
    logic       rnw;
    logic [7:0] wdata;
  } sla_host_req_s;

endpackage

// ### verilog/sla_fifo2.sv
`timescale 1ns/1ns
module sla_fifo2
  import sla_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];  // Storage array.
  logic [AW-1:0]    wr_ptr;       // Next slot to fill.
  logic [AW-1:0]    rd_ptr;       // Oldest slot.
  logic [AW:0]      count;        // Words held.
  logic             push;         // Accepted write.
  logic             pop;          // Accepted read.

  assign in_ready  = (count < (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Write side: storage is not reset since only counted slots are ever read.
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// ### bench/sla_adaptor_monitor.sv
`timescale 1ns/1ns
// Pin-level watch on the adaptor's handshakes, framing and host reads.
module sla_adaptor_monitor
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       mode_strap,
  input wire logic       serial_tx_pin,
  input wire logic       tx_side_valid,
  input wire logic       tx_side_ack,
  input wire logic [7:0] rx_side_bus,
  input wire logic       rx_side_valid,
  input wire logic       rx_side_ack,
  input wire logic       read_not_write,
  input wire logic       chip_select_n,
  input wire logic       host_bus_oe,
  input wire logic       rx_irq,
  input wire logic       tx_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [7:0] hi_run; // Length of the current high run on the link output.
  // A zero stop bit ends each packet, so no run passes ten slow bits.
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      hi_run <= 8'h00;
    else
      hi_run <= serial_tx_pin ? hi_run + 8'h01 : 8'h00;
  property p_rst_low; disable iff (1'b0) !rst_b |-> !serial_tx_pin; endproperty
  a_rst_low: assert property (p_rst_low) else $error("link out high in reset");
  property p_hi_run; hi_run <= 8'h78; endproperty
  a_hi_run: assert property (p_hi_run) else $error("link out high too long");
  property p_ack_late; $rose(tx_side_valid) && !tx_side_ack |=> !tx_side_ack [*8]; endproperty
  a_ack_late: assert property (p_ack_late) else $error("send ack too early");
  property p_ack_drop; tx_side_ack && !tx_side_valid |=> !tx_side_ack; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("send ack held");
  property p_qv_hold; rx_side_valid && !rx_side_ack |=> rx_side_valid && $stable(rx_side_bus); endproperty
  a_qv_hold: assert property (p_qv_hold) else $error("byte offer lost");
  property p_qv_drop; rx_side_valid && rx_side_ack |=> !rx_side_valid; endproperty
  a_qv_drop: assert property (p_qv_drop) else $error("byte offer held");
  property p_oe_cause; host_bus_oe |-> !$past(chip_select_n) && $past(read_not_write); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven off a read");
  property p_byte_irq; mode_strap |-> !tx_irq && !rx_irq; endproperty
  a_byte_irq: assert property (p_byte_irq) else $error("interrupt in byte mode");
  c_tx_done: cover property ($fell(tx_side_ack));
  c_rx_done: cover property ($fell(rx_side_valid));
  c_rx_irq: cover property (rx_irq && host_bus_oe);
endmodule
bind sla_adaptor sla_adaptor_monitor mon_u (.clk_sys(clk_sys), .rst_b(rst_b), .mode_strap(mode_strap),
  .serial_tx_pin(serial_tx_pin), .tx_side_valid(tx_side_valid), .tx_side_ack(tx_side_ack),
  .rx_side_bus(rx_side_bus), .rx_side_valid(rx_side_valid), .rx_side_ack(rx_side_ack),
  .read_not_write(read_not_write), .chip_select_n(chip_select_n), .host_bus_oe(host_bus_oe),
  .rx_irq(rx_irq), .tx_irq(tx_irq));

// ### bench/sla_link_peer.sv
`timescale 1ns/1ns
// Far end of the link: frames bytes onto the adaptor and decodes its output.
module sla_link_peer
(
  input  wire logic clk_sys,
  input  wire logic serial_tx_pin,
  output logic      serial_rx_pin
);
  int         bit_cyc = 12; // Bit period in system cycles.
  bit         early = 0;    // Acknowledge as soon as a byte starts.
  int         acks = 0;     // Acknowledge packets decoded.
  int         bad = 0;      // Data packets with a bad stop bit.
  int         pend[$];      // Packets to send; 256 marks an acknowledge.
  logic [7:0] got[$];       // Data bytes decoded.
  logic [7:0] b;            // Byte being assembled.
  // One packet at a time, so an acknowledge never cuts into data.
  task automatic send(input int p);
    logic [10:0] f;
    f = (p > 255) ? 11'h001 : {1'b0, p[7:0], 2'b11}; // Two ones, LSB first, zero.
    for (int i = 0; i < ((p > 255) ? 2 : 11); i++)
    begin
      serial_rx_pin <= f[i];
      repeat (bit_cyc) @(posedge clk_sys);
    end
    serial_rx_pin <= 1'b0; // The line rests low.
  endtask
  // Offers a byte and holds back the caller until it is acknowledged.
  task automatic send_byte(input logic [7:0] v);
    int a;
    a = acks;
    pend.push_back(int'(v));
    for (int i = 0; i < 4000 && acks == a; i++) @(posedge clk_sys);
  endtask
  // Sender.
  initial
  begin
    serial_rx_pin = 1'b0;
    forever
    begin
      @(posedge clk_sys);
      if (pend.size() > 0)
        send(pend.pop_front());
    end
  end
  // Decoder: samples each bit in its middle, counted from the first high cycle.
  initial
    forever
    begin
      @(posedge clk_sys);
      if (serial_tx_pin === 1'b1)
      begin
        repeat (bit_cyc + bit_cyc / 2) @(posedge clk_sys);
        if (serial_tx_pin !== 1'b1)
          acks++; // A one then a zero.
        else
        begin
          if (early) pend.push_back(256); // Ack at start of a byte.
          for (int i = 0; i < 8; i++)
          begin
            repeat (bit_cyc) @(posedge clk_sys);
            b[i] = serial_tx_pin;
          end
          repeat (bit_cyc) @(posedge clk_sys);
          if (serial_tx_pin !== 1'b0) bad++;
          got.push_back(b);
          if (!early) pend.push_back(256); // Slow ack after the stop bit.
        end
      end
    end
endmodule

// ### bench/test_serial_link_adaptor.sv
`timescale 1ns/1ns
`include "sla_regs.svh"
// Both byte-port rates, then register mode, against a link peer.
module test_serial_link_adaptor;
  logic       clk_sys, rst_b, mode_strap, fast, serial_rx_pin, serial_tx_pin;
  logic [7:0] tx_side_bus, rx_side_bus, host_bus_in, host_bus_out, rd, d;
  logic       tx_side_valid, tx_side_ack, rx_side_valid, rx_side_ack, host_bus_oe;
  logic       reg_select_low, reg_select_high, read_not_write, chip_select_n, rx_irq, tx_irq;
  int         num_errors, samples_checked, a0, junk;
  logic [7:0] exp_link[$]; // Bytes the peer should decode.
  logic [7:0] exp_rx[$];   // Bytes the byte port should offer.
  sla_adaptor dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .mode_strap(mode_strap),
    .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin), .tx_side_bus(tx_side_bus),
    .tx_side_valid(tx_side_valid), .tx_side_ack(tx_side_ack), .rx_side_bus(rx_side_bus),
    .rx_side_valid(rx_side_valid), .rx_side_ack(rx_side_ack), .reg_select_low(reg_select_low),
    .reg_select_high(reg_select_high), .read_not_write(read_not_write),
    .chip_select_n(chip_select_n), .host_bus_in(host_bus_in), .host_bus_out(host_bus_out),
    .host_bus_oe(host_bus_oe), .rx_irq(rx_irq), .tx_irq(tx_irq));
  sla_link_peer peer_u (.clk_sys(clk_sys), .serial_tx_pin(serial_tx_pin), .serial_rx_pin(serial_rx_pin));
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // In fast byte mode the strap carries the 5 MHz reference, toggled clear of clock edges.
  initial #1 forever #100 if (fast) mode_strap = ~mode_strap;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Resets with a strap setting, then waits out the strap window.
  task automatic restart(input logic s, input logic f);
    rst_b = 1'b0;
    fast = f;
    mode_strap = s;
    tick(4);
    rst_b = 1'b1;
    tick(80);
  endtask
  // One register access: select and data settle before chip select falls.
  task automatic host(input logic [1:0] s, input logic rnw, input logic [7:0] v);
    {reg_select_high, reg_select_low} = s;
    read_not_write = rnw;
    host_bus_in = v;
    tick(1);
    chip_select_n = 1'b0;
    tick(2);
    rd = host_bus_out;
    chk({7'h00, host_bus_oe}, {7'h00, rnw});
    chip_select_n = 1'b1;
    tick(2);
  endtask
  task automatic rd_chk(input logic [1:0] s, input logic [7:0] e);
    host(s, 1'b1, 8'h00);
    chk(rd, e);
  endtask
  task automatic put_byte(input logic [7:0] v);
    tx_side_bus = v;
    exp_link.push_back(v);
    tick(1);
    tx_side_valid = 1'b1; // The byte is already on the bus.
    for (int i = 0; i < 3000 && tx_side_ack !== 1'b1; i++) tick(1);
    chk({7'h00, tx_side_ack}, 8'h01);
    tx_side_valid = 1'b0;
    tick(1);
    chk({7'h00, tx_side_ack}, 8'h00);
  endtask
  task automatic feed(input int n);
    for (int k = 0; k < n; k++)
    begin
      d = 8'($urandom);
      exp_rx.push_back(d);
      peer_u.send_byte(d);
    end
  endtask
  // Consumer with random stalls; no link ack may go out before it accepts.
  task automatic take_bytes(input int n);
    int a;
    for (int k = 0; k < n; k++)
    begin
      for (int i = 0; i < 3000 && rx_side_valid !== 1'b1; i++) tick(1);
      a = peer_u.acks;
      chk(rx_side_bus, exp_rx.pop_front());
      tick($urandom_range(40));
      chk(8'(peer_u.acks - a), 8'h00);
      rx_side_ack = 1'b1;
      tick(2);
      chk({7'h00, rx_side_valid}, 8'h00);
      rx_side_ack = 1'b0;
      tick(1);
    end
  endtask
  task automatic print_verdict;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    {rst_b, mode_strap, fast, tx_side_valid, rx_side_ack, reg_select_low, reg_select_high} = '0;
    {read_not_write, chip_select_n, tx_side_bus, host_bus_in} = 18'h30000;
    num_errors = 0;
    samples_checked = 0;
    junk = $urandom(61);
    // Slow then fast byte mode, both directions at once.
    for (int m = 0; m < 2; m++)
    begin
      restart(1'b1, m[0]);
      peer_u.bit_cyc = m ? 6 : 12;
      peer_u.early = m[0];
      a0 = peer_u.acks;
      fork
        for (int k = 0; k < 4; k++) put_byte(8'($urandom));
        feed(4);
        take_bytes(4);
      join
      tick(200);
      chk(8'(peer_u.acks - a0), 8'h04);
      chk(8'(peer_u.bad), 8'h00);
      while (exp_link.size() > 0) chk(peer_u.got.pop_front(), exp_link.pop_front());
    end
    // Register mode.
    restart(1'b0, 1'b0);
    peer_u.bit_cyc = 12;
    peer_u.early = 1'b0;
    rd_chk(`SLA_SEL_RX_STAT, 8'h00);
    rd_chk(`SLA_SEL_TX_STAT, 8'h01);
    chk({6'h00, rx_irq, tx_irq}, 8'h00);
    host(`SLA_SEL_TX_STAT, 1'b0, 8'h02);
    tick(2);
    chk({6'h00, rx_irq, tx_irq}, 8'h01);
    d = 8'($urandom);
    host(`SLA_SEL_TX_BYTE, 1'b0, d);
    rd_chk(`SLA_SEL_TX_STAT, 8'h02);
    chk({6'h00, rx_irq, tx_irq}, 8'h00);
    tick(400);
    rd_chk(`SLA_SEL_TX_STAT, 8'h03);
    chk(peer_u.got.pop_front(), d);
    host(`SLA_SEL_RX_BYTE, 1'b0, 8'h5a);
    rd_chk(`SLA_SEL_RX_STAT, 8'h00);
    a0 = peer_u.acks;
    d = 8'($urandom);
    fork
      peer_u.send_byte(d);
    join_none
    tick(300);
    rd_chk(`SLA_SEL_RX_STAT, 8'h01);
    chk(8'(peer_u.acks - a0), 8'h00);
    host(`SLA_SEL_RX_STAT, 1'b0, 8'h02);
    tick(2);
    chk({6'h00, rx_irq, tx_irq}, 8'h03);
    rd_chk(`SLA_SEL_RX_BYTE, d);
    rd_chk(`SLA_SEL_RX_STAT, 8'h02);
    chk({6'h00, rx_irq, tx_irq}, 8'h01);
    tick(100);
    chk(8'(peer_u.acks - a0), 8'h01);
    rd_chk(`SLA_SEL_TX_BYTE, 8'h00);
    print_verdict;
  end
  // Watchdog well beyond the expected run of some three thousand cycles.
  initial
  begin
    #400000;
    num_errors++;
    print_verdict;
  end
endmodule
